// >>> common/capture_pkg.sv
// package for the fault parameter capture block
// assumes a 100 MHz clock and a command decoder in front of the block
package capture_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          REC_BYTES      = 32;
  localparam int          AUX_CAPTURE_BIT = 1;
  localparam logic [7:0]  STORE_LOAD     = 8'h01;
  localparam logic [7:0]  STORE_SAVE     = 8'h02;
  localparam int          SAVE_TIME_US   = 1400;
  localparam int          SAVE_CYCLES    = SAVE_TIME_US * CLK_MHZ;
  localparam logic        CAPTURE_RESET  = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_LOAD = 2'b10,
    ST_READ = 2'b11
  } state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cmd_type;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } byte_out_type;
endpackage

// >>> hdl/fault_parameter_capture.sv
// fault parameter capture: live record in ram, saved copy in flash store
// assumes commands arrive from an smbus decoder on the same clock
//
// Operation
// [RULE_01] aux setup bit 1 written one turns capture on, zero turns off
// [RULE_02] record returns as a 32-byte block read, allowed in normal running
// [RULE_03] capture on: ram record refreshed every control cycle; the code refreshes only in ST_IDLE, skipping cycles during save, load and read
// [RULE_04] capture off: ram record left alone, keeping fault values
// [RULE_05] host disables output and capture before fetching the flash copy
// [RULE_06] shutdown-response fault over threshold saves record to flash
// [RULE_07] retry-response faults never trigger the automatic save
// [RULE_08] store value 1 loads flash copy into ram for a later read
// [RULE_09] store value 2 saves record to flash, only while output disabled
// [RULE_10] a save is busy for 1400 us and is never interrupted
// [RULE_11] host should not store capture mode in default or user store
// [RULE_12] after a load the host reads, device returns ram contents
// [RULE_13] flash copy survives power cycling
// [RULE_14] capture enable accepted whether output enabled or not
// [RULE_15] other store values ignored, ram and flash unchanged
`timescale 1ns/1ps
module fault_parameter_capture (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // host commands
  input  wire capture_pkg::cmd_type      aux_setup_cmd,
  input  wire capture_pkg::cmd_type      store_ctrl_cmd,
  input  wire logic                      read_req,
  // power train status
  input  wire logic                      control_cycle,
  input  wire logic [8*32-1:0]           live_params,
  input  wire logic                      output_enabled,
  input  wire logic                      fault_over_limit,
  input  wire logic                      fault_resp_shutdown,
  // status and read data
  output logic                           capture_on,
  output logic                           busy,
  output capture_pkg::byte_out_type      read_byte
);
  capture_pkg::state_type state_reg, state_next;
  logic [7:0]  ram_reg [capture_pkg::REC_BYTES];
  logic [7:0]  ram_next [capture_pkg::REC_BYTES];
  logic        cap_reg, cap_next;
  logic [17:0] cnt_reg, cnt_next;
  logic [5:0]  idx_reg, idx_next;
  logic        busy_reg, busy_next;
  capture_pkg::byte_out_type out_reg, out_next;
  logic        fl_we;
  logic [4:0]  fl_addr;
  logic [7:0]  fl_rd;
  logic        auto_save;

  flash_store u_flash (
    .clock   (clock),
    .wr_en   (fl_we),
    .addr    (fl_addr),
    .wr_data (ram_reg[fl_addr]),
    .rd_data (fl_rd)
  );

  assign auto_save = fault_over_limit & fault_resp_shutdown; // [RULE_06] [RULE_07]

  always_comb begin
    state_next = state_reg;
    cap_next   = cap_reg;
    cnt_next   = cnt_reg;
    idx_next   = idx_reg;
    out_next   = '0;
    fl_we      = 1'b0;
    fl_addr    = idx_reg[4:0];
    for (int i = 0; i < capture_pkg::REC_BYTES; i++) begin
      ram_next[i] = ram_reg[i];
    end
    // no output gating on the enable write
    if (aux_setup_cmd.valid) begin
      cap_next = aux_setup_cmd.data[capture_pkg::AUX_CAPTURE_BIT]; // [RULE_01] [RULE_14]
    end
    // refresh only in idle so a save or load sees a stable record
    if (cap_reg && control_cycle && state_reg == capture_pkg::ST_IDLE) begin
      for (int i = 0; i < capture_pkg::REC_BYTES; i++) begin
        ram_next[i] = live_params[8*i +: 8]; // [RULE_03] [RULE_04]
      end
    end
    case (state_reg)
      capture_pkg::ST_IDLE: begin
        idx_next = '0;
        cnt_next = '0;
        if (auto_save) begin
          state_next = capture_pkg::ST_SAVE; // [RULE_06]
        end else if (store_ctrl_cmd.valid &&
                     store_ctrl_cmd.data == capture_pkg::STORE_LOAD) begin
          state_next = capture_pkg::ST_LOAD; // [RULE_08]
        end else if (store_ctrl_cmd.valid && !output_enabled &&
                     store_ctrl_cmd.data == capture_pkg::STORE_SAVE) begin
          state_next = capture_pkg::ST_SAVE; // [RULE_09] [RULE_15]
        end else if (read_req) begin
          state_next = capture_pkg::ST_READ; // [RULE_02] [RULE_12]
        end
      end
      capture_pkg::ST_SAVE: begin
        // programming time is held in full even though bytes finish early
        if (idx_reg < 6'(capture_pkg::REC_BYTES)) begin
          fl_we    = 1'b1;
          idx_next = idx_reg + 6'h01;
        end
        cnt_next = cnt_reg + 18'h00001;
        if (cnt_reg == 18'(capture_pkg::SAVE_CYCLES - 1)) begin
          state_next = capture_pkg::ST_IDLE; // [RULE_10]
        end
      end
      capture_pkg::ST_LOAD: begin
        // flash read data lags the address by one cycle
        fl_addr  = idx_reg[4:0];
        idx_next = idx_reg + 6'h01;
        if (idx_reg != 6'h00) begin
          ram_next[5'(idx_reg - 6'h01)] = fl_rd; // [RULE_08]
        end
        if (idx_reg == 6'(capture_pkg::REC_BYTES)) begin
          state_next = capture_pkg::ST_IDLE;
        end
      end
      capture_pkg::ST_READ: begin
        out_next.valid = 1'b1;
        out_next.data  = ram_reg[idx_reg[4:0]]; // [RULE_12]
        out_next.last  = (idx_reg == 6'(capture_pkg::REC_BYTES - 1));
        idx_next = idx_reg + 6'h01;
        if (out_next.last) begin
          state_next = capture_pkg::ST_IDLE; // [RULE_02]
        end
      end
      default: state_next = capture_pkg::ST_IDLE;
    endcase
    busy_next = (state_next != capture_pkg::ST_IDLE);
  end

  // record ram has no reset so a reset does not wipe fault values
  always_ff @(posedge clock) begin
    for (int i = 0; i < capture_pkg::REC_BYTES; i++) begin
      ram_reg[i] <= ram_next[i];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= capture_pkg::ST_IDLE;
      cap_reg   <= capture_pkg::CAPTURE_RESET;
      cnt_reg   <= '0;
      idx_reg   <= '0;
      busy_reg  <= 1'b0;
      out_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cap_reg   <= cap_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      busy_reg  <= busy_next;
      out_reg   <= out_next;
    end
  end

  assign capture_on = cap_reg;
  assign busy       = busy_reg;
  assign read_byte  = out_reg;

  chk_capture_follows: assert property (@(posedge clock) disable iff (sys_rst)
    aux_setup_cmd.valid |=> capture_on == $past(aux_setup_cmd.data[1]))
    else $error("capture mode not set from aux write"); // [RULE_01]
  chk_ram_frozen: assert property (@(posedge clock) disable iff (sys_rst)
    (!cap_reg && state_reg == capture_pkg::ST_IDLE) |=> $stable(ram_reg[0]))
    else $error("ram record changed while capture off"); // [RULE_04]
  chk_ram_refresh: assert property (@(posedge clock) disable iff (sys_rst)
    (cap_reg && control_cycle && state_reg == capture_pkg::ST_IDLE)
    |=> ram_reg[0] == $past(live_params[7:0]))
    else $error("ram record not refreshed"); // [RULE_03]
  chk_auto_save: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == capture_pkg::ST_IDLE && auto_save)
    |=> state_reg == capture_pkg::ST_SAVE)
    else $error("shutdown fault did not start save"); // [RULE_06]
  chk_no_retry_save: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == capture_pkg::ST_IDLE && !fault_resp_shutdown &&
     !store_ctrl_cmd.valid) |=> state_reg != capture_pkg::ST_SAVE)
    else $error("save started without shutdown fault"); // [RULE_07]
  chk_save_gated: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == capture_pkg::ST_IDLE && !auto_save && output_enabled)
    |=> state_reg != capture_pkg::ST_SAVE)
    else $error("manual save while output enabled"); // [RULE_09]
  chk_save_length: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(state_reg == capture_pkg::ST_SAVE) |-> busy [*8])
    else $error("save interrupted early"); // [RULE_10]
  chk_load_start: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == capture_pkg::ST_IDLE && !auto_save &&
     store_ctrl_cmd.valid && store_ctrl_cmd.data == 8'h01)
    |=> state_reg == capture_pkg::ST_LOAD ##33 state_reg == capture_pkg::ST_IDLE)
    else $error("load sequence wrong"); // [RULE_08]
  chk_ignore_other: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == capture_pkg::ST_IDLE && !auto_save && !read_req &&
     store_ctrl_cmd.valid && store_ctrl_cmd.data > 8'h02)
    |=> state_reg == capture_pkg::ST_IDLE)
    else $error("bad store value acted on"); // [RULE_15]
  chk_read_len: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(read_byte.valid) |-> ##31 read_byte.last)
    else $error("block read not 32 bytes"); // [RULE_02]
endmodule

// >>> hdl/flash_store.sv
// nonvolatile copy of the capture record
// assumes the array maps onto a retention memory that keeps its contents
`timescale 1ns/1ps
module flash_store (
  // clock
  input  wire logic       clock,
  // access
  input  wire logic       wr_en,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);
  // no reset on purpose: the copy must survive a power cycle
  logic [7:0] mem [capture_pkg::REC_BYTES];
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[addr] <= wr_data; // [RULE_13]
    end
    rd_data <= mem[addr];
  end
endmodule

// >>> tb/host_model.sv
// host controller model: sends management commands and gathers block reads
// assumes the bench clock; drives its requests on the falling edge
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic                      clock,
  // commands toward the device
  output capture_pkg::cmd_type           aux_setup_cmd,
  output capture_pkg::cmd_type           store_ctrl_cmd,
  output logic                           read_req,
  // block read data
  input  wire capture_pkg::byte_out_type read_byte
);
  logic [7:0] rx_data [$];
  int         rx_last;
  initial begin
    aux_setup_cmd  = '0;
    store_ctrl_cmd = '0;
    read_req       = 1'b0;
  end
  // capture mode is only ever written here, never to a config store
  task automatic send(input logic is_store, input logic [7:0] v);
    @(negedge clock);
    if (is_store) store_ctrl_cmd = '{valid: 1'b1, data: v};
    else aux_setup_cmd = '{valid: 1'b1, data: v};
    @(negedge clock);
    aux_setup_cmd  = '0;
    store_ctrl_cmd = '0;
  endtask
  // one 32-byte block read; the bench may leave capture on during it
  task automatic read_block();
    rx_data.delete();
    rx_last = -1;
    @(negedge clock);
    read_req = 1'b1;
    @(negedge clock);
    read_req = 1'b0;
    repeat (40) begin
      @(negedge clock);
      if (read_byte.valid === 1'b1) begin
        if (read_byte.last === 1'b1) rx_last = rx_data.size();
        rx_data.push_back(read_byte.data);
      end
    end
  endtask
endmodule

// >>> tb/testbench.sv
// bench for the fault parameter capture block
// assumes one save lasts the full package save time; no shorter parameter
`timescale 1ns/1ps
module testbench;
  logic                      clock = 1'b0;
  logic                      sys_rst = 1'b1;
  capture_pkg::cmd_type      aux_setup_cmd;
  capture_pkg::cmd_type      store_ctrl_cmd;
  logic                      read_req;
  logic                      control_cycle = 1'b0;
  logic [8*32-1:0]           live_params = '0;
  logic                      output_enabled = 1'b0;
  logic                      fault_over_limit = 1'b0;
  logic                      fault_resp_shutdown = 1'b0;
  logic                      capture_on;
  logic                      busy;
  capture_pkg::byte_out_type read_byte;
  int mismatches = 0, cmp_count = 0, cycles = 0, n, cap_model = 0;
  int ram_model [32];
  int flash_model [32];
  always #5 clock = ~clock;
  fault_parameter_capture i_fault_parameter_capture (.clock(clock),
    .sys_rst(sys_rst), .aux_setup_cmd(aux_setup_cmd),
    .store_ctrl_cmd(store_ctrl_cmd), .read_req(read_req),
    .control_cycle(control_cycle), .live_params(live_params),
    .output_enabled(output_enabled), .fault_over_limit(fault_over_limit),
    .fault_resp_shutdown(fault_resp_shutdown), .capture_on(capture_on),
    .busy(busy), .read_byte(read_byte));
  host_model i_host (.clock(clock), .aux_setup_cmd(aux_setup_cmd),
    .store_ctrl_cmd(store_ctrl_cmd), .read_req(read_req),
    .read_byte(read_byte));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // fresh live values and one control cycle tick
  task automatic tick_capture();
    @(negedge clock);
    for (int i = 0; i < 32; i++) begin
      live_params[8*i +: 8] = 8'($urandom);
      if (cap_model == 1) ram_model[i] = live_params[8*i +: 8];
    end
    control_cycle = 1'b1;
    @(negedge clock);
    control_cycle = 1'b0;
  endtask
  task automatic check_read();
    i_host.read_block();
    check("read count", i_host.rx_data.size(), 32);
    check("last index", i_host.rx_last, 31);
    foreach (i_host.rx_data[i])
      check("read byte", i_host.rx_data[i], ram_model[i]);
  endtask
  task automatic set_capture(input int on);
    i_host.send(1'b0, 8'(on) << capture_pkg::AUX_CAPTURE_BIT);
    cap_model = on;
    check("capture mode", capture_on, on);
  endtask
  // a save is long, so the ceiling sits just above one save
  always @(posedge clock) begin
    cycles++;
    if (cycles == 150000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    n = $urandom(32'hBE73);
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    check("reset capture", capture_on, 0);
    check("reset busy", busy, 0);
    for (int e = 0; e < 2; e++) begin
      output_enabled = e[0];
      set_capture(1);
      set_capture(0);
    end
    set_capture(1);
    tick_capture();
    check_read();
    set_capture(0);
    tick_capture();
    check_read();
    fault_over_limit = 1'b1;
    @(negedge clock);
    fault_over_limit = 1'b0;
    check("retry fault", busy, 0);
    i_host.send(1'b1, capture_pkg::STORE_SAVE);
    check("save while on", busy, 0);
    for (int k = 0; k < 3; k++) begin
      i_host.send(1'b1, k == 0 ? 8'h00 : (k == 1 ? 8'h03 : 8'hFF));
      check("ignored value", busy, 0);
    end
    check_read();
    fault_over_limit = 1'b1;
    fault_resp_shutdown = 1'b1;
    @(negedge clock);
    fault_over_limit = 1'b0;
    fault_resp_shutdown = 1'b0;
    check("save start", busy, 1);
    n = 0;
    while (busy === 1'b1 && n < 145000) begin
      @(negedge clock);
      n++;
    end
    check("save length", n, capture_pkg::SAVE_CYCLES);
    flash_model = ram_model;
    set_capture(1);
    tick_capture();
    set_capture(0);
    output_enabled = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    i_host.send(1'b1, capture_pkg::STORE_LOAD);
    check("load busy", busy, 1);
    for (int w = 0; w < 200 && busy !== 1'b0; w++) @(negedge clock);
    check("load done", busy, 0);
    ram_model = flash_model;
    check_read();
    // manual save accepted with output off; run ends before it completes
    i_host.send(1'b1, capture_pkg::STORE_SAVE);
    check("manual save", busy, 1);
    test_done();
  end
endmodule
